//--- hdl/can_tx_select_abort_ack_filter_ctrl.sv
// Transmit select, abort acknowledge and acceptance control registers
module can_tx_select_abort_ack_filter_ctrl
    import can_sel_pkg::*;
(
    input  wire logic                        CORE_CLK_I,   // 10 MHz clock
    input  wire logic                        ARST_N_I,     // Async reset
    input  wire logic                        PSEL_I,       // APB select
    input  wire logic                        PENABLE_I,    // APB enable
    input  wire logic                        PWRITE_I,     // APB write
    input  wire logic [can_sel_pkg::ADDR_W-1:0] PADDR_I,   // APB address
    input  wire logic [can_sel_pkg::DATA_W-1:0] PWDATA_I,  // APB wr data
    output logic      [can_sel_pkg::DATA_W-1:0] PRDATA_O,  // APB rd data
    output logic                             PREADY_O,     // APB ready
    output logic                             PSLVERR_O,    // APB error
    input  wire logic                        INIT_REQ_I,   // Init request
    input  wire logic                        INIT_ACK_I,   // Init ack
    input  wire logic [2:0]                  TX_SENT_I,    // Msg sent
    input  wire logic [2:0]                  ABORT_GRANT_I,// Abort done
    input  wire logic                        RX_SHIFT_I,   // Rx to fg
    input  wire logic [2:0]                  RX_HIT_I,     // Rx filter
    output logic      [2:0]                  TX_EMPTY_O,   // Empty flags
    output logic      [2:0]                  ABORT_DONE_O, // Abort flags
    output logic      [2:0]                  WIN_SEL_O,    // Window buf
    output logic                             WIN_ALLOW_O,  // Window ok
    output can_sel_pkg::filter_mode_t        FILTER_MODE_O,// Filter org
    output logic      [2:0]                  HIT_INDEX_O,  // Hit index
    output logic                             FG_RELOAD_O,  // Fg reload
    output logic                             IRQ_O         // Interrupt
);
    import can_sel_pkg::*;

    // Reset release through two flip-flops
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!rst_n);

    logic [2:0]  tbsel_q;
    logic [2:0]  stat_q;
    logic [2:0]  mask_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [2:0]  win_sel_q;
    logic        win_allow_q;
    logic        irq_q;
    filter_mode_t mode;
    logic [2:0]  hit;
    logic        reload;

    txbuf_if #(.N(NUM_TXBUF)) tb ();

    // Decode of the APB access
    wire         init_mode = INIT_REQ_I & INIT_ACK_I;
    wire         run_mode  = ~INIT_REQ_I & ~INIT_ACK_I;
    wire         access    = PSEL_I & PENABLE_I;
    wire         done_acc  = access & pready_q;
    wire         wr_acc    = done_acc & PWRITE_I;
    wire [7:0]   wbyte     = PWDATA_I[7:0];
    wire         hit_taak  = (PADDR_I == TAAK_OFS);
    wire         hit_tbsel = (PADDR_I == TBSEL_OFS);
    wire         hit_idac  = (PADDR_I == IDAC_OFS);
    wire         hit_rsvd  = (PADDR_I == RSVD_OFS);
    wire         hit_tflg  = (PADDR_I == TFLG_OFS);
    wire         hit_stat  = (PADDR_I == IRQ_STAT_OFS);
    wire         hit_mask  = (PADDR_I == IRQ_MASK_OFS);
    wire         mapped    = hit_taak | hit_tbsel | hit_idac | hit_rsvd |
                             hit_tflg | hit_stat | hit_mask;
    wire         wr_tbsel  = wr_acc & hit_tbsel & run_mode;
    wire         wr_idac   = wr_acc & hit_idac & init_mode;
    wire         wr_tflg   = wr_acc & hit_tflg;
    wire         wr_stat   = wr_acc & hit_stat;
    wire         wr_mask   = wr_acc & hit_mask;

    // Lowest set bit picks the buffer; a raw value with more bits is kept
    // so software can simply copy the flag register in
    wire [2:0]   sel_low   = tbsel_q & (~tbsel_q + 3'h1);
    wire         allow_d   = |(sel_low & tb.empty);

    // Flag tracker controls; software clears an empty flag by writing one
    assign tb.sent  = TX_SENT_I;
    assign tb.grant = ABORT_GRANT_I;
    assign tb.clr   = wr_tflg ? wbyte[2:0] : 3'h0;
    assign tb.init  = init_mode;

    // Read data, upper bits zero
    wire [7:0]   rd_taak   = {5'h00, tb.done};
    wire [7:0]   rd_tbsel  = {5'h00, sel_low};
    wire [7:0]   rd_idac   = {2'h0, mode, 1'b0, hit};
    wire [7:0]   rd_tflg   = {5'h00, tb.empty};
    wire [7:0]   rd_stat   = {5'h00, stat_q};
    wire [7:0]   rd_mask   = {5'h00, mask_q};
    wire [7:0]   rd_byte   = hit_taak  ? rd_taak  :
                             hit_tbsel ? rd_tbsel :
                             hit_idac  ? rd_idac  :
                             hit_rsvd  ? RSVD_VAL :
                             hit_tflg  ? rd_tflg  :
                             hit_stat  ? rd_stat  :
                             hit_mask  ? rd_mask  : 8'h00;

    // Interrupt status: set wins over a write-one clear
    wire [2:0]   stat_clr  = wr_stat ? wbyte[2:0] : 3'h0;
    wire [2:0]   stat_d    = tb.evt | (stat_q & ~stat_clr);

    tx_flag_track #(.N(NUM_TXBUF)) u_flags (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (rst_n),
        .tb      (tb)
    );

    filter_hit_track u_filter (
        .clk_i     (CORE_CLK_I),
        .rst_n_i   (rst_n),
        .mode_we_i (wr_idac),
        .mode_i    (wbyte[ACCEPT_FILTER_MODE_LSB+1:ACCEPT_FILTER_MODE_LSB]),
        .shift_i   (RX_SHIFT_I),
        .hit_i     (RX_HIT_I),
        .mode_o    (mode),
        .hit_o     (hit),
        .reload_o  (reload)
    );

    // APB answer: ready one cycle into the access phase
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            if (access && !pready_q && !PWRITE_I)
                prdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // Buffer select, held in reset during init mode
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n)
            tbsel_q <= TBSEL_RST;
        else if (init_mode)
            tbsel_q <= TBSEL_RST;
        else if (wr_tbsel)
            tbsel_q <= wbyte[2:0];
    end

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= IRQ_RST;
            mask_q <= IRQ_RST;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            if (wr_mask)
                mask_q <= wbyte[2:0];
            irq_q  <= |(stat_q & mask_q);
        end
    end

    // Window outputs lag the select register by one cycle
    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            win_sel_q   <= 3'h0;
            win_allow_q <= 1'b0;
        end else begin
            win_sel_q   <= sel_low;
            win_allow_q <= allow_d;
        end
    end

    assign PRDATA_O      = prdata_q;
    assign PREADY_O      = pready_q;
    assign PSLVERR_O     = pslverr_q;
    assign TX_EMPTY_O    = tb.empty;
    assign ABORT_DONE_O  = tb.done;
    assign WIN_SEL_O     = win_sel_q;
    assign WIN_ALLOW_O   = win_allow_q;
    assign FILTER_MODE_O = mode;
    assign HIT_INDEX_O   = hit;
    assign FG_RELOAD_O   = reload;
    assign IRQ_O         = irq_q;

    // Checks
    sequence s_apb_read(logic [7:0] a);
        access && !pready_q && !PWRITE_I && PADDR_I == a;
    endsequence
    sequence s_answer;
        pready_q;
    endsequence

    chk_tbsel_init: assert property (
        init_mode |=> (tbsel_q == TBSEL_RST))
        else $error("select register not held in init mode");
    chk_tbsel_write: assert property (
        (wr_acc && hit_tbsel && !run_mode && !init_mode) |=>
        $stable(tbsel_q))
        else $error("select written outside run mode");
    chk_tbsel_read: assert property (
        s_apb_read(TBSEL_OFS) ##1 s_answer |->
        (prdata_q[2:0] == $past(sel_low) && prdata_q[31:3] == 29'h0))
        else $error("select read not lowest bit");
    chk_rsvd_zero: assert property (
        s_apb_read(RSVD_OFS) ##1 s_answer |-> (prdata_q == 32'h0))
        else $error("reserved register read nonzero");
    chk_win_none: assert property (
        (tbsel_q == 3'h0) |=> !win_allow_q)
        else $error("window open with no buffer selected");
    chk_win_block: assert property (
        (sel_low != 3'h0 && (sel_low & tb.empty) == 3'h0) |=>
        !win_allow_q)
        else $error("window open on scheduled buffer");
    chk_win_lowest: assert property (
        tbsel_q[0] |=> (win_sel_q == 3'h1))
        else $error("window picked wrong buffer");
    chk_idac_guard: assert property (
        (wr_acc && hit_idac && !init_mode) |=> $stable(mode))
        else $error("filter mode changed outside init mode");
    chk_taak_ro: assert property (
        (wr_acc && hit_taak && tb.grant == 3'h0 &&
         tb.clr == 3'h0 && !init_mode) |=> $stable(tb.done))
        else $error("abort done flags took a write");
    chk_irq_level: assert property (
        (stat_q & mask_q) != 3'h0 |=> irq_q)
        else $error("interrupt missing for pending status");
    chk_slverr: assert property (
        (access && !pready_q && !mapped) |=> (pready_q && pslverr_q))
        else $error("unmapped access without error");

    // APB answer timing and read data
    chk_ready_next: assert property (
        (access && !pready_q) |=> pready_q)
        else $error("no ready after access phase");
    chk_ready_pulse: assert property (
        pready_q |=> !pready_q)
        else $error("ready held longer than one cycle");
    chk_slverr_map: assert property (
        (access && !pready_q && mapped) |=> !pslverr_q)
        else $error("error on a mapped register");
    chk_slverr_ready: assert property (
        pslverr_q |-> pready_q)
        else $error("error without ready");
    chk_rdata_hold: assert property (
        !(access && !pready_q && !PWRITE_I) |=> $stable(prdata_q))
        else $error("read data changed without a read");
    chk_taak_read: assert property (
        s_apb_read(TAAK_OFS) ##1 s_answer |->
        (prdata_q == {29'h0, $past(tb.done)}))
        else $error("abort done read wrong");
    chk_tflg_read: assert property (
        s_apb_read(TFLG_OFS) ##1 s_answer |->
        (prdata_q == {29'h0, $past(tb.empty)}))
        else $error("empty flag read wrong");
    chk_idac_read: assert property (
        s_apb_read(IDAC_OFS) ##1 s_answer |->
        (prdata_q[2:0] == $past(hit) && prdata_q[5:4] == $past(mode) &&
         prdata_q[31:6] == 26'h0 && !prdata_q[3]))
        else $error("acceptance control read wrong");
    chk_stat_read: assert property (
        s_apb_read(IRQ_STAT_OFS) ##1 s_answer |->
        (prdata_q == {29'h0, $past(stat_q)}))
        else $error("status read wrong");
    chk_mask_read: assert property (
        s_apb_read(IRQ_MASK_OFS) ##1 s_answer |->
        (prdata_q == {29'h0, $past(mask_q)}))
        else $error("mask read wrong");

    // Register writes, select and window
    chk_tbsel_take: assert property (
        wr_tbsel |=> (tbsel_q == $past(wbyte[2:0])))
        else $error("select write lost");
    chk_tbsel_hold: assert property (
        (!init_mode && !wr_tbsel) |=> $stable(tbsel_q))
        else $error("select changed without a write");
    chk_idac_take: assert property (
        (wr_acc && hit_idac && init_mode) |=>
        (mode == $past(wbyte[ACCEPT_FILTER_MODE_LSB+1:ACCEPT_FILTER_MODE_LSB])))
        else $error("filter mode write lost in init mode");
    chk_win_second: assert property (
        (tbsel_q[1:0] == 2'h2) |=> (win_sel_q == 3'h2))
        else $error("window did not pick buffer one");
    chk_win_third: assert property (
        (tbsel_q == 3'h4) |=> (win_sel_q == 3'h4))
        else $error("window did not pick buffer two");
    chk_win_empty: assert property (
        (tbsel_q == 3'h0) |=> (win_sel_q == 3'h0))
        else $error("window shows a buffer with none selected");
    chk_win_open: assert property (
        ((sel_low & tb.empty) != 3'h0) |=> win_allow_q)
        else $error("window closed on an empty buffer");

    // Interrupt status, init mode and foreground buffer
    chk_stat_set: assert property (
        (tb.evt != 3'h0) |=> ((stat_q & $past(tb.evt)) == $past(tb.evt)))
        else $error("event did not set its status bit");
    chk_stat_clear: assert property (
        (wr_stat && tb.evt == 3'h0) |=>
        ((stat_q & $past(wbyte[2:0])) == 3'h0))
        else $error("status bit not cleared by write");
    chk_mask_take: assert property (
        wr_mask |=> (mask_q == $past(wbyte[2:0])))
        else $error("mask write lost");
    chk_irq_low: assert property (
        ((stat_q & mask_q) == 3'h0) |=> !irq_q)
        else $error("interrupt with no pending status");
    chk_taak_init: assert property (
        init_mode |=> (tb.done == TAAK_RST))
        else $error("abort done flags not held in init mode");
    chk_empty_init: assert property (
        init_mode |=> (tb.empty == TFLG_RST))
        else $error("empty flags not held in init mode");
    chk_fg_closed: assert property (
        (mode == MODE_CLOSED) |=> !reload)
        else $error("foreground reloaded with filter closed");
    chk_hit_follow: assert property (
        (RX_SHIFT_I && mode != MODE_CLOSED) |=>
        (reload && hit == $past(RX_HIT_I)))
        else $error("hit index did not follow the shift");
endmodule

//--- shared/can_sel_pkg.sv
// Package: register map, reset values and encodings of the select block
package can_sel_pkg;
    localparam int          NUM_TXBUF    = 3;
    localparam int          REG_W        = 8;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    // Byte addresses of the registers
    localparam logic [7:0]  TAAK_OFS     = 8'h00;
    localparam logic [7:0]  TBSEL_OFS    = 8'h04;
    localparam logic [7:0]  IDAC_OFS     = 8'h08;
    localparam logic [7:0]  RSVD_OFS     = 8'h0c;
    localparam logic [7:0]  TFLG_OFS     = 8'h10;
    localparam logic [7:0]  IRQ_STAT_OFS = 8'h14;
    localparam logic [7:0]  IRQ_MASK_OFS = 8'h18;
    // Field positions
    localparam int          ACCEPT_FILTER_MODE_LSB     = 4;
    localparam int          ACCEPT_FILTER_HIT_INDEX_LSB    = 0;
    // Values after reset
    localparam logic [2:0]  TBSEL_RST    = 3'h0;
    localparam logic [2:0]  TAAK_RST     = 3'h0;
    localparam logic [2:0]  TFLG_RST     = 3'h7;
    localparam logic [2:0]  IRQ_RST      = 3'h0;
    localparam logic [2:0]  HIT_RST      = 3'h0;
    localparam logic [7:0]  RSVD_VAL     = 8'h00;
    // Acceptance filter organisation
    typedef enum logic [1:0] {
        MODE_TWO_32,
        MODE_FOUR_16,
        MODE_EIGHT_8,
        MODE_CLOSED
    } filter_mode_t;
    localparam filter_mode_t ACCEPT_FILTER_MODE_RST    = MODE_TWO_32;
endpackage

//--- shared/txbuf_if.sv
// Interface between the register logic and the transmit flag tracker
interface txbuf_if #(parameter int N = 3);
    logic [N-1:0] sent;
    logic [N-1:0] grant;
    logic [N-1:0] clr;
    logic         init;
    logic [N-1:0] empty;
    logic [N-1:0] done;
    logic [N-1:0] evt;
    modport ctrl  (output sent, grant, clr, init,
                   input  empty, done, evt);
    modport flags (input  sent, grant, clr, init,
                   output empty, done, evt);
endinterface

//--- hdl/tx_flag_track.sv
// Per-buffer empty and abort done flags
module tx_flag_track
    import can_sel_pkg::*;
#(
    parameter int N = NUM_TXBUF
) (
    input  wire logic clk_i,   // Core clock
    input  wire logic rst_n_i, // Synchronised reset
    txbuf_if.flags    tb       // Flag controls and state
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    for (genvar i = 0; i < N; i++) begin : g_buf
        logic empty_q;
        logic done_q;
        wire  set_w = tb.sent[i] | tb.grant[i];
        // Set wins over a clear in the same cycle
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                empty_q <= TFLG_RST[i];
                done_q  <= TAAK_RST[i];
            end else if (tb.init) begin
                empty_q <= TFLG_RST[i];
                done_q  <= TAAK_RST[i];
            end else begin
                empty_q <= set_w | (empty_q & ~tb.clr[i]);
                // Cleared together with the empty flag
                done_q  <= tb.grant[i] |
                           (done_q & ~(tb.clr[i] & ~set_w));
            end
        end
        assign tb.empty[i] = empty_q;
        assign tb.done[i]  = done_q;
        assign tb.evt[i]   = set_w & ~tb.init;

        chk_done_init: assert property (
            tb.init |=> !done_q)
            else $error("abort done flag set in init mode");
        chk_done_clear: assert property (
            (tb.clr[i] && empty_q && !set_w && !tb.init) |=>
            (!empty_q && !done_q))
            else $error("abort done not cleared with empty flag");
        chk_grant_both: assert property (
            (tb.grant[i] && !tb.init) |=> (empty_q && done_q))
            else $error("abort grant did not set both flags");
        chk_sent_empty: assert property (
            (tb.sent[i] && !tb.grant[i] && !tb.init && !done_q) |=>
            (empty_q && !done_q))
            else $error("sent message did not free buffer");
    end
endmodule

//--- hdl/filter_hit_track.sv
// Acceptance filter organisation and hit index of the foreground buffer
module filter_hit_track
    import can_sel_pkg::*;
(
    input  wire logic         clk_i,    // Core clock
    input  wire logic         rst_n_i,  // Synchronised reset
    input  wire logic         mode_we_i,// Mode write, init mode only
    input  wire logic [1:0]   mode_i,   // Written mode value
    input  wire logic         shift_i,  // Message reaches foreground
    input  wire logic [2:0]   hit_i,    // Filter that matched it
    output filter_mode_t      mode_o,   // Current organisation
    output logic [2:0]        hit_o,    // Hit index of foreground msg
    output logic              reload_o  // Foreground buffer reloaded
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    filter_mode_t mode_q;
    logic [2:0]   hit_q;
    logic         reload_q;
    wire          accept_w = shift_i && (mode_q != MODE_CLOSED);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q   <= ACCEPT_FILTER_MODE_RST;
            hit_q    <= HIT_RST;
            reload_q <= 1'b0;
        end else begin
            if (mode_we_i)
                mode_q <= filter_mode_t'(mode_i);
            if (accept_w)
                hit_q <= hit_i;
            reload_q <= accept_w;
        end
    end
    assign mode_o   = mode_q;
    assign hit_o    = hit_q;
    assign reload_o = reload_q;

    chk_closed_noreload: assert property (
        (mode_q == MODE_CLOSED && !mode_we_i) |=> !reload_q)
        else $error("foreground reloaded in closed mode");
    chk_hit_update: assert property (
        accept_w |=> (reload_q && hit_q == $past(hit_i)))
        else $error("hit index not updated on shift");
    chk_hit_stable: assert property (
        !accept_w |=> $stable(hit_q))
        else $error("hit index changed without a shift");
endmodule

//--- tb/can_engine_model.sv
// Behavioural model of the protocol engine side of the select block
module can_engine_model (
    input  wire logic       clk_i,         // Core clock
    output logic      [2:0] tx_sent_o,     // Message sent pulses
    output logic      [2:0] abort_grant_o, // Abort granted pulses
    output logic            rx_shift_o,    // Message into foreground
    output logic      [2:0] rx_hit_o       // Filter of that message
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        tx_sent_o     = 3'h0;
        abort_grant_o = 3'h0;
        rx_shift_o    = 1'b0;
        rx_hit_o      = 3'h0;
    end

    // One-cycle completion pulse for buffer i, a send or a granted abort
    task automatic pulse(input logic is_abort, input int i);
        @(posedge clk_i);
        if (is_abort)
            abort_grant_o <= 3'h1 << i;
        else
            tx_sent_o <= 3'h1 << i;
        @(posedge clk_i);
        abort_grant_o <= 3'h0;
        tx_sent_o     <= 3'h0;
    endtask

    // Hit lines are only meaningful with the strobe, so they show garbage after
    task automatic shift(input logic [2:0] h);
        @(posedge clk_i);
        rx_shift_o <= 1'b1;
        rx_hit_o   <= h;
        @(posedge clk_i);
        rx_shift_o <= 1'b0;
        rx_hit_o   <= ~h;
    endtask
endmodule

//--- tb/can_tx_select_abort_ack_filter_ctrl_tb.sv
// Self-checking bench of the transmit select and acceptance control block
module can_tx_select_abort_ack_filter_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import can_sel_pkg::*;

    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0, prdata, rd_q;
    logic         pready, pslverr, err_q, rx_shift, irq, reload, win_ok;
    logic         init_req = 1'b0, init_ack = 1'b0;
    logic [2:0]   sent, grant, rx_hit, empty, adone, win_sel, hit;
    filter_mode_t fmode;
    int           fail_count = 0, samples_checked = 0, cyc = 0;

    always #50 clk = ~clk;

    can_engine_model u_can_engine_model (
        .clk_i(clk), .tx_sent_o(sent), .abort_grant_o(grant),
        .rx_shift_o(rx_shift), .rx_hit_o(rx_hit));

    can_tx_select_abort_ack_filter_ctrl
        u_can_tx_select_abort_ack_filter_ctrl (
        .CORE_CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .INIT_REQ_I(init_req), .INIT_ACK_I(init_ack),
        .TX_SENT_I(sent), .ABORT_GRANT_I(grant), .RX_SHIFT_I(rx_shift),
        .RX_HIT_I(rx_hit), .TX_EMPTY_O(empty), .ABORT_DONE_O(adone),
        .WIN_SEL_O(win_sel), .WIN_ALLOW_O(win_ok), .FILTER_MODE_O(fmode),
        .HIT_INDEX_O(hit), .FG_RELOAD_O(reload), .IRQ_O(irq));

    task automatic stop_test;
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // The full run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h, not %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One APB transfer; data and error are taken at the ready edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait that never gets an answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_reset;
        apb(0, TAAK_OFS, 0);  check(rd_q, 32'h0);
        apb(0, TBSEL_OFS, 0); check(rd_q, 32'h0);
        apb(0, IDAC_OFS, 0);  check(rd_q, 32'h0);
        apb(0, TFLG_OFS, 0);  check(rd_q, 32'h7);
        apb(1, RSVD_OFS, 32'hff);
        apb(0, RSVD_OFS, 0);  check(rd_q, 32'h0);
        apb(0, 8'h20, 0);     check(err_q, 1'b1);
        $display("reset test done");
    endtask

    task automatic t_select;
        apb(0, TFLG_OFS, 0);
        apb(1, TBSEL_OFS, rd_q);
        apb(0, TBSEL_OFS, 0); check(rd_q, 32'h1);
        tick(2); check(win_sel, 3'h1);
        check(win_ok, 1'b1);
        apb(1, TBSEL_OFS, 32'h6);
        apb(0, TBSEL_OFS, 0); check(rd_q, 32'h2);
        tick(2); check(win_sel, 3'h2);
        apb(1, TBSEL_OFS, 32'hff);
        apb(0, TBSEL_OFS, 0); check(rd_q, 32'h1);
        apb(1, TBSEL_OFS, 32'h0);
        tick(2); check(win_ok, 1'b0);
        $display("select test done");
    endtask

    task automatic t_abort;
        apb(1, IRQ_MASK_OFS, 32'h7);
        apb(0, IRQ_MASK_OFS, 0); check(rd_q, 32'h7);
        apb(1, TBSEL_OFS, 32'h2);
        apb(1, TFLG_OFS, 32'h2);
        tick(2); check(empty, 3'h5);
        check(win_ok, 1'b0);
        u_can_engine_model.pulse(1'b1, 1);
        #1; check(empty, 3'h7);
        check(adone, 3'h2);
        tick(1); check(irq, 1'b1);
        apb(1, TAAK_OFS, 32'h0);
        apb(0, TAAK_OFS, 0);  check(rd_q, 32'h2);
        apb(1, TFLG_OFS, 32'h2);
        tick(1); check(adone, 3'h0);
        u_can_engine_model.pulse(1'b0, 1);
        #1; check({empty, adone}, 6'h38);
        apb(1, IRQ_STAT_OFS, 32'h7);
        tick(2); check(irq, 1'b0);
        apb(1, IRQ_MASK_OFS, 32'h0);
        apb(1, TFLG_OFS, 32'h1);
        u_can_engine_model.pulse(1'b1, 0);
        tick(2); check(irq, 1'b0);
        check(adone, 3'h1);
        apb(0, IRQ_STAT_OFS, 0); check(rd_q, 32'h1);
        $display("abort test done");
    endtask

    task automatic t_init;
        apb(1, TBSEL_OFS, 32'h4);
        apb(1, IDAC_OFS, 32'h30);
        apb(0, IDAC_OFS, 0);  check(rd_q, 32'h0);
        init_req <= 1'b1;
        apb(1, TBSEL_OFS, 32'h1);
        apb(0, TBSEL_OFS, 0); check(rd_q, 32'h4);
        init_ack <= 1'b1;
        tick(2); check(adone, 3'h0);
        apb(0, TAAK_OFS, 0);  check(rd_q, 32'h0);
        apb(0, TBSEL_OFS, 0); check(rd_q, 32'h0);
        apb(1, TBSEL_OFS, 32'h1);
        apb(0, TBSEL_OFS, 0); check(rd_q, 32'h0);
        for (int m = 3; m >= 0; m--) begin
            apb(1, IDAC_OFS, (m << ACCEPT_FILTER_MODE_LSB) | 7);
            apb(0, IDAC_OFS, 0); check(rd_q, m << ACCEPT_FILTER_MODE_LSB);
            check(fmode, m);
        end
        init_req <= 1'b0;
        init_ack <= 1'b0;
        apb(1, TBSEL_OFS, 32'h1);
        apb(0, TBSEL_OFS, 0); check(rd_q, 32'h1);
        $display("init test done");
    endtask

    task automatic t_hit;
        for (int h = 0; h < 8; h++) begin
            u_can_engine_model.shift(h);
            #1; check(reload, 1'b1);
            check(hit, h);
            apb(0, IDAC_OFS, 0); check(rd_q, h);
        end
        init_req <= 1'b1;
        init_ack <= 1'b1;
        apb(1, IDAC_OFS, 32'h30);
        init_req <= 1'b0;
        init_ack <= 1'b0;
        tick(1); check(fmode, MODE_CLOSED);
        u_can_engine_model.shift(3'h2);
        #1; check(reload, 1'b0);
        check(hit, 3'h7);
        $display("hit test done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_select();
        t_abort();
        t_init();
        t_hit();
        stop_test();
    end
endmodule
